// ---- pbs_assertions.sv ----
// Purpose: wire checks between controller end and sram end
// Assumes: one clock, async active-low reset
// Notes:   takes interface signals as plain inputs
`timescale 1ns/1ps
`include "pbs_regs.svh"
module pbs_assertions (
   input wire logic                   CLK,
   input wire logic                   RESETN,
   input wire logic                   load_or_step_ctl,
   input wire logic                   rw_n,
   input wire logic                   clock_gate_n,
   input wire logic [`PBS_LANES-1:0]  byte_lane_write_n,
   input wire logic                   chip_select_low_a,
   input wire logic                   chip_select_pair_b,
   input wire logic                   chip_select_pair_b_n,
   input wire logic                   dq_ctl_oe,
   input wire logic                   dq_mem_oe,
   input wire logic [`PBS_DATA_W-1:0] dq_mem_o
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic ld;
   // load of a new address taken by the sram end
   assign ld = !clock_gate_n && !load_or_step_ctl && !chip_select_low_a && chip_select_pair_b;
   property p_sel;
      chip_select_pair_b != chip_select_low_a && chip_select_pair_b_n == chip_select_low_a;
   endproperty
   a_sel: assert property (p_sel) else $error("select polarity wrong");
   property p_rd; (ld && rw_n) ##1 !clock_gate_n |=> dq_mem_oe; endproperty
   a_rd: assert property (p_rd) else $error("read beat late");
   property p_rd_beats; (ld && rw_n) ##1 !clock_gate_n ##1 1'b1 |=> dq_mem_oe [*3]; endproperty
   a_rd_beats: assert property (p_rd_beats) else $error("read burst short");
   property p_wr_rel; (ld && !rw_n) ##1 !clock_gate_n |=> !dq_mem_oe [*4]; endproperty
   a_wr_rel: assert property (p_wr_rel) else $error("bus not released on write");
   property p_wr_drv; (ld && !rw_n) ##1 !clock_gate_n |=> dq_ctl_oe; endproperty
   a_wr_drv: assert property (p_wr_drv) else $error("write data not driven");
   property p_gate; clock_gate_n |=> $stable(dq_mem_oe) && $stable(dq_mem_o); endproperty
   a_gate: assert property (p_gate) else $error("state moved on gated edge");
   property p_step; ld |=> (load_or_step_ctl || clock_gate_n) [*3]; endproperty
   a_step: assert property (p_step) else $error("burst cut short");
   property p_lanes;
      (ld && !rw_n) |-> byte_lane_write_n == `PBS_LANE_ALL
         ##1 (clock_gate_n || byte_lane_write_n == `PBS_LANE_ALL) [*3];
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane enables missing");
endmodule

// ---- pbs_ctl.sv ----
// Purpose: controller end, issues four-word bursts, buffers read data
// Assumes: user side is logic on CLK
// Notes:   read beats go through a fifo; full fifo stalls new reads
`timescale 1ns/1ps
`include "pbs_regs.svh"
module pbs_ctl #(
   parameter int AW = `PBS_ADDR_W,
   parameter int DW = `PBS_DATA_W,
   parameter int NL = `PBS_LANES
) (
   input  wire logic          CLK,
   input  wire logic          RESETN,
   input  wire logic          CE,
   input  wire logic          REQ_VALID,
   input  wire logic          REQ_WRITE,
   input  wire logic [AW-1:0] REQ_ADDR,
   input  wire logic [DW-1:0] REQ_WDATA,
   input  wire logic          REQ_ORDER,
   output logic               REQ_READY,
   output logic [DW-1:0]      RD_DATA,
   output logic               RD_VALID,
   input  wire logic          RD_READY,
   pbs_if.ctl                 BUS
);
   logic [1:0]    beat_reg, beat_next;
   logic          busy_reg, busy_next, wr_reg, wr_next;
   logic [AW-1:0] a_reg, a_next;
   logic [DW-1:0] wd_reg, wd_next, wd1_reg, wd1_next, wd2_reg, wd2_next;
   logic [1:0]    rp1_reg, rp2_reg, wp1_reg, wp2_reg;
   logic [1:0]    rp1_next, rp2_next, wp1_next, wp2_next;
   logic          load, step, fifo_ready;
   logic [4:0]    room_reg, room_next;
   logic          rd_room;
   // fifo room covers reads still in flight
   always_comb begin
      rd_room = fifo_ready && (room_reg <= 5'(`PBS_DEPTH - `PBS_BEATS));
      load = REQ_VALID && !busy_reg && (REQ_WRITE || rd_room);
      step = busy_reg;
      busy_next = load ? 1'b1 : (busy_reg && beat_reg != `PBS_BEAT_LAST);
      beat_next = load ? 2'h1 : (step ? beat_reg + 2'h1 : beat_reg);
      wr_next = load ? REQ_WRITE : wr_reg;
      a_next = load ? REQ_ADDR : a_reg;
      wd_next = REQ_WDATA;
      wd1_next = wd_reg;
      wd2_next = wd1_reg;
      rp1_next = {1'b0, (load && !REQ_WRITE) || (step && !wr_reg)};
      wp1_next = {1'b0, (load && REQ_WRITE) || (step && wr_reg)};
      rp2_next = rp1_reg;
      wp2_next = wp1_reg;
      room_next = room_reg + 5'(rp1_next[0]) - 5'(RD_VALID && RD_READY);
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         busy_reg <= 1'b0; beat_reg <= 2'h0; wr_reg <= 1'b0; a_reg <= '0;
         wd_reg <= '0; wd1_reg <= '0; wd2_reg <= '0; room_reg <= '0;
         rp1_reg <= 2'h0; rp2_reg <= 2'h0; wp1_reg <= 2'h0; wp2_reg <= 2'h0;
      end else if (CE) begin
         busy_reg <= busy_next; beat_reg <= beat_next; wr_reg <= wr_next; a_reg <= a_next;
         wd_reg <= wd_next; wd1_reg <= wd1_next; wd2_reg <= wd2_next; room_reg <= room_next;
         rp1_reg <= rp1_next; rp2_reg <= rp2_next; wp1_reg <= wp1_next; wp2_reg <= wp2_next;
      end
   end
   // pin drive: selects move together, lanes all on for writes
   assign BUS.addr = REQ_ADDR;
   assign BUS.load_or_step_ctl = busy_reg;                      // idle cycles are deselect loads
   assign BUS.rw_n = !REQ_WRITE;
   assign BUS.clock_gate_n = !CE;
   assign BUS.byte_lane_write_n = `PBS_LANE_ALL;
   assign BUS.burst_order_select = REQ_ORDER;
   assign BUS.chip_select_low_a = !load && !busy_reg;
   assign BUS.chip_select_pair_b = load || busy_reg;
   assign BUS.chip_select_pair_b_n = !load && !busy_reg;
   assign BUS.dq_ctl_o = wd1_reg;
   assign BUS.dq_ctl_oe = wp2_reg[0];
   assign REQ_READY = !busy_reg && (REQ_WRITE || rd_room);
   pbs_fifo #(.WIDTH(DW), .DEPTH(`PBS_DEPTH)) u_fifo (
      .CLK(CLK), .RESETN(RESETN), .CE(CE),
      .IN_DATA(BUS.dq), .IN_VALID(rp2_reg[0]), .IN_READY(fifo_ready),
      .OUT_DATA(RD_DATA), .OUT_VALID(RD_VALID), .OUT_READY(RD_READY)
   );
endmodule

// ---- pbs_fifo.sv ----
// Purpose: small valid/ready fifo for read data
// Assumes: single clock, clock enable freezes state
// Notes:   full and empty are exact
`timescale 1ns/1ps
`include "pbs_regs.svh"
module pbs_fifo #(
   parameter int WIDTH = `PBS_DATA_W,
   parameter int DEPTH = `PBS_DEPTH
) (
   input  wire logic             CLK,
   input  wire logic             RESETN,
   input  wire logic             CE,
   input  wire logic [WIDTH-1:0] IN_DATA,
   input  wire logic             IN_VALID,
   output logic                  IN_READY,
   output logic [WIDTH-1:0]      OUT_DATA,
   output logic                  OUT_VALID,
   input  wire logic             OUT_READY
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;
   // pointer and count update
   always_comb begin
      push     = IN_VALID && (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
      pop      = OUT_READY && (cnt_reg != '0);
      wp_next  = push ? wp_reg + 1'b1 : wp_reg;
      rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else if (CE) begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end
   // storage without reset
   always_ff @(posedge CLK) begin
      if (CE && push) begin
         mem[wp_reg] <= IN_DATA;
      end
   end
   assign IN_READY  = cnt_reg != (AW+1)'(DEPTH);
   assign OUT_VALID = cnt_reg != '0;
   assign OUT_DATA  = mem[rp_reg];
endmodule

// ---- pbs_if.sv ----
// Purpose: pin bundle between controller and sram port
// Assumes: one clock shared by both ends
// Notes:   data bus resolved from both output enables
`timescale 1ns/1ps
`include "pbs_regs.svh"
interface pbs_if;
   logic [`PBS_ADDR_W-1:0]  addr;
   logic                    load_or_step_ctl;
   logic                    rw_n;
   logic                    clock_gate_n;
   logic [`PBS_LANES-1:0]   byte_lane_write_n;
   logic                    burst_order_select;
   logic                    chip_select_low_a;
   logic                    chip_select_pair_b;
   logic                    chip_select_pair_b_n;
   logic [`PBS_DATA_W-1:0]  dq_ctl_o;
   logic                    dq_ctl_oe;
   logic [`PBS_DATA_W-1:0]  dq_mem_o;
   logic                    dq_mem_oe;
   logic [`PBS_DATA_W-1:0]  dq;
   // wired bus level
   assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
   modport ctl (output addr, load_or_step_ctl, rw_n, clock_gate_n, byte_lane_write_n,
                output burst_order_select, chip_select_low_a, chip_select_pair_b,
                output chip_select_pair_b_n, dq_ctl_o, dq_ctl_oe, input dq);
   modport mem (input addr, load_or_step_ctl, rw_n, clock_gate_n, byte_lane_write_n,
                input burst_order_select, chip_select_low_a, chip_select_pair_b,
                input chip_select_pair_b_n, output dq_mem_o, dq_mem_oe, input dq);
endinterface

// ---- pbs_mem.sv ----
// Purpose: device end, pipelined burst sram with two cycle data latency
// Assumes: pins come from logic on the same clock; no documented reset, RESETN used
// Notes:   clock_gate_n high freezes every register
// Notes on behaviour
// - burst steps two low address bits, order select
// - burst ends only on sampled load
// - read/write ignored while stepping
// - burst direction fixed at load
// - controller drives lane enables every write beat
// - write starts on load with rw low
// - lane enables lead write data two cycles
// - gate high edge ignored, state held
// - active-high select opposite to low selects
`timescale 1ns/1ps
`include "pbs_regs.svh"
module pbs_mem #(
   parameter int AW = `PBS_ADDR_W,
   parameter int DW = `PBS_DATA_W,
   parameter int NL = `PBS_LANES
) (
   input  wire logic CLK,
   input  wire logic RESETN,
   pbs_if.mem        BUS
);
   localparam int LW = DW / NL;
   logic [DW-1:0] arr [2**AW];
   pbs_pkg::pbs_op_t    op_reg, op_next;
   logic [AW-1:0]       base_reg, base_next;
   logic [1:0]          cnt_reg, cnt_next;
   pbs_pkg::pbs_op_t    p1_op_reg, p1_op_next, p2_op_reg, p2_op_next;
   logic [AW-1:0]       p1_a_reg, p1_a_next, p2_a_reg, p2_a_next;
   logic [NL-1:0]       p1_be_reg, p1_be_next, p2_be_reg, p2_be_next;
   logic [DW-1:0]       q_reg, q_next;
   logic                oe_reg, oe_next;
   logic                sel, run;
   logic                ord_reg, ord_next;
   logic [1:0]          idx;
   logic [AW-1:0]       cur_a;
   // burst position: linear adds, interleaved xors
   function automatic logic [1:0] beat_pos(input logic [1:0] b, input logic [1:0] c,
                                           input logic ord);
      beat_pos = ord ? (b + c) : (b ^ c);
   endfunction
   // command decode and burst counter
   always_comb begin
      sel = !BUS.chip_select_low_a && BUS.chip_select_pair_b && !BUS.chip_select_pair_b_n;
      run = (op_reg != pbs_pkg::PBS_IDLE);
      op_next = op_reg;
      base_next = base_reg;
      cnt_next = cnt_reg;
      ord_next = ord_reg;
      if (!BUS.load_or_step_ctl) begin
         base_next = BUS.addr;
         ord_next  = BUS.burst_order_select;                    // order held for the burst
         cnt_next  = `PBS_BEAT_ZERO;
         if (!sel) op_next = pbs_pkg::PBS_IDLE;
         else if (!BUS.rw_n) op_next = pbs_pkg::PBS_WRITE;
         else op_next = pbs_pkg::PBS_READ;
      end else if (run) begin
         cnt_next = cnt_reg + 2'h1;                             // rw_n not looked at
      end
      idx = beat_pos(base_next[1:0], cnt_next, ord_next);
      cur_a = {base_next[AW-1:2], idx};
      p1_op_next = op_next;
      p1_a_next = cur_a;
      p1_be_next = BUS.byte_lane_write_n;                       // taken with command
      p2_op_next = p1_op_reg;
      p2_a_next = p1_a_reg;
      p2_be_next = p1_be_reg;
      oe_next = (p1_op_reg == pbs_pkg::PBS_READ);
      q_next = arr[p1_a_reg];
   end
   // all state held while gate is high
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         op_reg <= pbs_pkg::PBS_IDLE;
         base_reg <= '0;
         cnt_reg <= `PBS_BEAT_ZERO;
         ord_reg <= 1'b0;
         p1_op_reg <= pbs_pkg::PBS_IDLE;
         p2_op_reg <= pbs_pkg::PBS_IDLE;
         p1_a_reg <= '0;
         p2_a_reg <= '0;
         p1_be_reg <= `PBS_LANE_NONE;
         p2_be_reg <= `PBS_LANE_NONE;
         q_reg <= '0;
         oe_reg <= 1'b0;
      end else if (!BUS.clock_gate_n) begin
         op_reg <= op_next;
         base_reg <= base_next;
         cnt_reg <= cnt_next;
         ord_reg <= ord_next;
         p1_op_reg <= p1_op_next;
         p2_op_reg <= p2_op_next;
         p1_a_reg <= p1_a_next;
         p2_a_reg <= p2_a_next;
         p1_be_reg <= p1_be_next;
         p2_be_reg <= p2_be_next;
         q_reg <= q_next;
         oe_reg <= oe_next;
      end
   end
   // write data lands two cycles after its lane enables
   always_ff @(posedge CLK) begin
      for (int g = 0; g < NL; g++) begin
         if (!BUS.clock_gate_n && p2_op_reg == pbs_pkg::PBS_WRITE && !p2_be_reg[g]) begin
            arr[p2_a_reg][g*LW +: LW] <= BUS.dq[g*LW +: LW];
         end
      end
   end
   assign BUS.dq_mem_o  = q_reg;
   assign BUS.dq_mem_oe = oe_reg;
endmodule

// ---- pbs_pkg.sv ----
// Purpose: shared types for the burst sram port
// Assumes: pbs_regs.svh holds the numbers
// Notes:   state encodings only
package pbs_pkg;
   typedef enum logic [1:0] {
      PBS_IDLE  = 2'b00,
      PBS_READ  = 2'b01,
      PBS_WRITE = 2'b10
   } pbs_op_t;
endpackage

// ---- pbs_regs.svh ----
// Purpose: named constants for the pipelined burst sram port
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_ADDR_W    17
`define PBS_DATA_W    36
`define PBS_LANES     4
`define PBS_DEPTH     16
`define PBS_PIPE_LAT  2
`define PBS_BEATS     4
`define PBS_BEAT_LAST 2'h3
`define PBS_BEAT_ZERO 2'h0
`define PBS_LANE_ALL  4'h0
`define PBS_LANE_NONE 4'hF
`endif

// ---- pipelined_burst_sram_port_tb_top.sv ----
// Purpose: both ends joined; bursts written, read back, fifo filled
// Assumes: controller writes one word value per burst
// Notes:   expected read words noted at request time
`timescale 1ns/1ps
`include "pbs_regs.svh"
module pipelined_burst_sram_port_tb_top;
   logic                   clk, rst_n, ce, req_valid, req_write, req_order, req_ready;
   logic                   rd_valid, rd_ready;
   logic [`PBS_ADDR_W-1:0] req_addr;
   logic [`PBS_DATA_W-1:0] req_wdata, rd_data, shadow [8], exp_q [$];
   logic [15:0]            lfsr_reg;
   int                     err_count, total_checks;
   pbs_if u_pbs_if ();
   pbs_mem u_pbs_mem (.CLK(clk), .RESETN(rst_n), .BUS(u_pbs_if.mem));
   pbs_ctl u_pbs_ctl (.CLK(clk), .RESETN(rst_n), .CE(ce), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_ORDER(req_order),
      .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready),
      .BUS(u_pbs_if.ctl));
   pbs_assertions u_pbs_assertions (.CLK(clk), .RESETN(rst_n),
      .load_or_step_ctl(u_pbs_if.load_or_step_ctl), .rw_n(u_pbs_if.rw_n),
      .clock_gate_n(u_pbs_if.clock_gate_n), .byte_lane_write_n(u_pbs_if.byte_lane_write_n),
      .chip_select_low_a(u_pbs_if.chip_select_low_a),
      .chip_select_pair_b(u_pbs_if.chip_select_pair_b),
      .chip_select_pair_b_n(u_pbs_if.chip_select_pair_b_n), .dq_ctl_oe(u_pbs_if.dq_ctl_oe),
      .dq_mem_oe(u_pbs_if.dq_mem_oe), .dq_mem_o(u_pbs_if.dq_mem_o));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [`PBS_DATA_W-1:0] got, input logic [`PBS_DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one burst request; held until taken, read words noted
   task automatic req(input logic wr, input logic [2:0] grp);
      int n;
      lfsr_reg = lfsr_next(lfsr_reg);
      @(negedge clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = {12'h000, grp, lfsr_reg[1:0]};
      req_order = lfsr_reg[14];
      if (wr)
         req_wdata = {lfsr_reg[3:0], lfsr_reg, ~lfsr_reg};
      if (wr)
         shadow[grp] = req_wdata;
      else
         repeat (4) exp_q.push_back(shadow[grp]);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(req_ready === 1'b1 && ce) && n < 500);
      if (n >= 500)
         chk(36'h0, 36'h1);
      @(negedge clk) req_valid = 1'b0;
      if (wr)
         repeat (16) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // read beats against oldest note; wire checks
   always @(posedge clk) begin
      if (rst_n && ce && rd_valid === 1'b1 && rd_ready)
         chk(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      if (rst_n && ce && u_pbs_if.load_or_step_ctl === 1'b0 && u_pbs_if.rw_n === 1'b0
          && u_pbs_if.chip_select_low_a === 1'b0)
         chk(36'(u_pbs_if.byte_lane_write_n), 36'(`PBS_LANE_ALL));
      if (rst_n)
         chk(36'({u_pbs_if.chip_select_pair_b, u_pbs_if.chip_select_pair_b_n}
            ^ {2{u_pbs_if.chip_select_low_a}}), 36'h2);
   end
   // reset, writes, fifo fill and drain, gated random traffic
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      req_wdata = '0;
      req_order = 1'b0;
      rd_ready = 1'b1;
      lfsr_reg = 16'h000C;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      for (int i = 0; i < 8; i++) req(1'b1, i[2:0]);
      rd_ready = 1'b0;
      for (int i = 0; i < 4; i++) req(1'b0, i[2:0]);
      fork
         begin
            repeat (30) @(negedge clk);
            chk(36'(req_ready), 36'h0);
            rd_ready = 1'b1;
         end
      join_none
      req(1'b0, 3'h4);
      fork
         forever begin
            @(negedge clk);
            lfsr_reg = lfsr_next(lfsr_reg);
            ce = lfsr_reg[0] | lfsr_reg[1];
            rd_ready = lfsr_reg[2] | lfsr_reg[3];
         end
      join_none
      for (int i = 0; i < 12; i++) req(lfsr_reg[4], lfsr_reg[7:5]);
      repeat (400) if (exp_q.size() != 0) @(negedge clk);
      chk(36'(exp_q.size()), 36'h0);
      close_out();
   end
   initial begin
      #100000;
      chk(36'h0, 36'h1);
      close_out();
   end
endmodule
